// ==== rtl/ulsl_pkg.sv ====
// Purpose: constants for the uart line-status logic
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets of all registers are chosen locally
package ulsl_pkg;
  // ==========================================================
  // fifo geometry
  localparam int unsigned FIFO_DEPTH = 64;
  localparam int unsigned PTR_W = 6;
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h40;
  localparam logic [6:0] CNT_ONE = 7'h01;
  localparam logic [5:0] PTR_ONE = 6'h01;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] ADDR_LINE_STATUS = 8'h00;
  localparam logic [7:0] ADDR_RX_HOLDING = 8'h04;
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h08;
  localparam logic [7:0] ADDR_FIFO_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // ==========================================================
  // line status bit positions
  localparam int unsigned LS_DR = 0;
  localparam int unsigned LS_OE = 1;
  localparam int unsigned LS_PE = 2;
  localparam int unsigned LS_FE = 3;
  localparam int unsigned LS_BI = 4;
  localparam int unsigned LS_THRE = 5;
  localparam int unsigned LS_TEMT = 6;
  localparam int unsigned LS_FERR = 7;
  // fifo control bit positions
  localparam int unsigned FC_EN = 0;
  localparam int unsigned FC_RXRST = 1;
  // irq status bits: rx char, overrun, error char, tx empty
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_RX = 0;
  localparam int unsigned IRQ_OVR = 1;
  localparam int unsigned IRQ_ERR = 2;
  localparam int unsigned IRQ_TXE = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  localparam logic [7:0] BREAK_CHAR = 8'h00;
  localparam logic [2:0] FLAGS_NONE = 3'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : ulsl_pkg

// ==== rtl/ulsl_line_status.sv ====
// Purpose: line status byte and receive fifo with per-character flags
// Assumes: character framing sits outside; received chars arrive as pulses
// Notes: one clock, apb slave with zero wait states
//
// Notes on behaviour
// - bit 7 high while any flagged character remains in receive fifo.
// - bit 6 high only when holding and shift registers both empty.
// - bit 5 high when holding register empty; fifo takes 64 bytes while enable bit is one, one byte otherwise.
// - a whole low frame stores character 00 with break flag set.
// - bit 3 shows missing stop bit of head character.
// - bit 2 shows parity failure of head character.
// - bit 1 high once a receive overrun occurred.
// - bit 0 high while receive fifo holds a character.
// - after reset error and data-ready bits read zero.
// - bits 4:2 show flags of the oldest fifo character.
// - head flags drive bus bits 4:2 directly, no extra flops.
// - status read leaves the read pointer unchanged.
// - each receive holding read of a non-empty fifo advances the read pointer by one while the enable bit is one.
// - only error bits may be stale on first read above 36 MHz.
// - fifos in use only while enable bit is one; resets zero.
// - receive fifo reset empties fifo and clears itself.
`timescale 1ns/1ps
module ulsl_line_status (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_parity_bad,
  input wire logic rx_stop_bad,
  input wire logic rx_frame_low,
  input wire logic tx_shift_empty,
  input wire logic tx_take,
  output logic tx_char_valid,
  output logic [7:0] tx_char_data,
  output logic irq
);
  // ==========================================================
  // reset release
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire logic rst_ni = rst_s2_reg;

  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = p + ulsl_pkg::PTR_ONE;
  endfunction : ptr_inc

  // ==========================================================
  // bus decode
  wire logic acc = psel && penable;
  wire logic [7:0] a8 = paddr[7:0];
  wire logic rd_ls = acc && !pwrite && a8 == ulsl_pkg::ADDR_LINE_STATUS;
  wire logic rd_rhr = acc && !pwrite && a8 == ulsl_pkg::ADDR_RX_HOLDING;
  wire logic wr_thr = acc && pwrite && a8 == ulsl_pkg::ADDR_TX_HOLDING;
  wire logic wr_fc = acc && pwrite && a8 == ulsl_pkg::ADDR_FIFO_CTRL;
  wire logic wr_ist = acc && pwrite && a8 == ulsl_pkg::ADDR_IRQ_STATUS;
  wire logic wr_imk = acc && pwrite && a8 == ulsl_pkg::ADDR_IRQ_MASK;
  wire logic mapped = a8 == ulsl_pkg::ADDR_LINE_STATUS || a8 == ulsl_pkg::ADDR_RX_HOLDING
    || a8 == ulsl_pkg::ADDR_TX_HOLDING || a8 == ulsl_pkg::ADDR_FIFO_CTRL
    || a8 == ulsl_pkg::ADDR_IRQ_STATUS || a8 == ulsl_pkg::ADDR_IRQ_MASK;
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || paddr[31:8] != 24'h000000);

  // ==========================================================
  // fifo control
  logic fifo_en_reg, rx_rst_reg;
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      fifo_en_reg <= 1'b0;
      rx_rst_reg <= 1'b0;
    end else begin
      if (wr_fc) fifo_en_reg <= pwdata[ulsl_pkg::FC_EN];
      rx_rst_reg <= wr_fc && pwdata[ulsl_pkg::FC_RXRST];
    end
  end
  // a change of fifo mode empties both fifos so pointers never disagree
  wire logic mode_chg = wr_fc && (pwdata[ulsl_pkg::FC_EN] != fifo_en_reg);

  // ==========================================================
  // receive fifo: data plus break, framing, parity flags
  logic [7:0] rx_data_mem [ulsl_pkg::FIFO_DEPTH];
  logic [2:0] rx_flag_mem [ulsl_pkg::FIFO_DEPTH];
  logic [5:0] rx_wp_reg, rx_rp_reg;
  logic [6:0] rx_cnt_reg, err_cnt_reg;
  logic ovr_reg;
  wire logic [6:0] rx_cap = fifo_en_reg ? ulsl_pkg::FIFO_FULL_CNT : ulsl_pkg::CNT_ONE;
  wire logic rx_full = rx_cnt_reg >= rx_cap;
  wire logic rx_empty = rx_cnt_reg == 7'h00;
  wire logic push = rx_char_valid && !rx_full;
  wire logic pop = rd_rhr && !rx_empty;
  wire logic [2:0] in_flags = {rx_frame_low, rx_frame_low ? 1'b0 : rx_stop_bad,
    rx_frame_low ? 1'b0 : rx_parity_bad};
  wire logic [7:0] in_data = rx_frame_low ? ulsl_pkg::BREAK_CHAR : rx_char_data;
  wire logic [2:0] head_flags = rx_empty ? ulsl_pkg::FLAGS_NONE : rx_flag_mem[rx_rp_reg];
  wire logic in_err = |in_flags;
  wire logic out_err = |head_flags;
  wire logic [6:0] rx_cnt_next = rx_cnt_reg + 7'(push) - 7'(pop);
  wire logic [6:0] err_cnt_next = err_cnt_reg + 7'(push && in_err) - 7'(pop && out_err);

  always_ff @(posedge clk) begin
    if (push) begin
      rx_data_mem[rx_wp_reg] <= in_data;
      rx_flag_mem[rx_wp_reg] <= in_flags;
    end
  end

  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      rx_wp_reg <= 6'h00;
      rx_rp_reg <= 6'h00;
      rx_cnt_reg <= 7'h00;
      err_cnt_reg <= 7'h00;
    end else if (rx_rst_reg || mode_chg) begin
      rx_wp_reg <= 6'h00;
      rx_rp_reg <= 6'h00;
      rx_cnt_reg <= 7'h00;
      err_cnt_reg <= 7'h00;
    end else begin
      if (push) rx_wp_reg <= fifo_en_reg ? ptr_inc(rx_wp_reg) : rx_wp_reg;
      if (pop) rx_rp_reg <= fifo_en_reg ? ptr_inc(rx_rp_reg) : rx_rp_reg;
      rx_cnt_reg <= rx_cnt_next;
      err_cnt_reg <= err_cnt_next;
    end
  end

  // overrun: set wins over the read clear
  wire logic ovr_set = rx_char_valid && rx_full;
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) ovr_reg <= 1'b0;
    else ovr_reg <= ovr_set || (ovr_reg && !rd_ls);
  end

  // ==========================================================
  // transmit holding fifo
  logic [7:0] tx_mem [ulsl_pkg::FIFO_DEPTH];
  logic [5:0] tx_wp_reg, tx_rp_reg;
  logic [6:0] tx_cnt_reg;
  wire logic [6:0] tx_cap = fifo_en_reg ? ulsl_pkg::FIFO_FULL_CNT : ulsl_pkg::CNT_ONE;
  wire logic tx_empty = tx_cnt_reg == 7'h00;
  wire logic tx_push = wr_thr && tx_cnt_reg < tx_cap;
  wire logic tx_pop = tx_take && !tx_empty;
  always_ff @(posedge clk) begin
    if (tx_push) tx_mem[tx_wp_reg] <= pwdata[7:0];
  end
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      tx_wp_reg <= 6'h00;
      tx_rp_reg <= 6'h00;
      tx_cnt_reg <= 7'h00;
    end else if (mode_chg) begin
      tx_wp_reg <= 6'h00;
      tx_rp_reg <= 6'h00;
      tx_cnt_reg <= 7'h00;
    end else begin
      if (tx_push) tx_wp_reg <= fifo_en_reg ? ptr_inc(tx_wp_reg) : tx_wp_reg;
      if (tx_pop) tx_rp_reg <= fifo_en_reg ? ptr_inc(tx_rp_reg) : tx_rp_reg;
      tx_cnt_reg <= tx_cnt_reg + 7'(tx_push) - 7'(tx_pop);
    end
  end
  assign tx_char_valid = !tx_empty;
  assign tx_char_data = tx_empty ? ulsl_pkg::BREAK_CHAR : tx_mem[tx_rp_reg];

  // ==========================================================
  // line status byte; break, framing and parity bits come straight from head entry
  wire logic [7:0] line_status_reg;
  assign line_status_reg[ulsl_pkg::LS_FERR] = err_cnt_reg != 7'h00;
  assign line_status_reg[ulsl_pkg::LS_TEMT] = tx_empty && tx_shift_empty;
  assign line_status_reg[ulsl_pkg::LS_THRE] = tx_empty;
  assign line_status_reg[ulsl_pkg::LS_BI:ulsl_pkg::LS_PE] = head_flags;
  assign line_status_reg[ulsl_pkg::LS_OE] = ovr_reg;
  assign line_status_reg[ulsl_pkg::LS_DR] = !rx_empty;

  // ==========================================================
  // interrupts
  logic [3:0] ist_reg, imk_reg;
  wire logic [3:0] ev = {tx_pop && tx_cnt_reg == ulsl_pkg::CNT_ONE, push && in_err, ovr_set,
    push};
  always_ff @(posedge clk or negedge rst_ni) begin
    if (!rst_ni) begin
      ist_reg <= ulsl_pkg::IRQ_RESET;
      imk_reg <= ulsl_pkg::IRQ_RESET;
    end else begin
      ist_reg <= ev | (ist_reg & ~(wr_ist ? pwdata[3:0] : 4'h0));
      if (wr_imk) imk_reg <= pwdata[3:0];
    end
  end
  assign irq = |(ist_reg & imk_reg);

  // ==========================================================
  // read data
  wire logic [31:0] rd_mux =
    !acc || pwrite ? ulsl_pkg::READ_ZERO :
    a8 == ulsl_pkg::ADDR_LINE_STATUS ? {24'h000000, line_status_reg} :
    a8 == ulsl_pkg::ADDR_RX_HOLDING ? {24'h000000, rx_empty ? 8'h00 : rx_data_mem[rx_rp_reg]} :
    a8 == ulsl_pkg::ADDR_FIFO_CTRL ? {31'h00000000, fifo_en_reg} :
    a8 == ulsl_pkg::ADDR_IRQ_STATUS ? {28'h0000000, ist_reg} :
    a8 == ulsl_pkg::ADDR_IRQ_MASK ? {28'h0000000, imk_reg} : ulsl_pkg::READ_ZERO;
  assign prdata = rd_mux;

  // ==========================================================
  // checks
  sequence s_clean_push;
    push && !pop && !rx_rst_reg && !mode_chg;
  endsequence
  sequence s_clean_pop;
    pop && !push && !rx_rst_reg && !mode_chg;
  endsequence
  sequence s_first_char;
    rx_empty ##0 s_clean_push;
  endsequence

  // error summary and transmit bits
  a_ferr_tracks_cnt: assert property (@(posedge clk) disable iff (!rst_ni)
    rx_empty |-> !line_status_reg[ulsl_pkg::LS_FERR])
    else $error("fifo error bit set with empty fifo");
  a_err_le_cnt: assert property (@(posedge clk) disable iff (!rst_ni)
    err_cnt_reg <= rx_cnt_reg)
    else $error("error count above fill count");
  a_temt_both: assert property (@(posedge clk) disable iff (!rst_ni)
    line_status_reg[ulsl_pkg::LS_TEMT] |-> line_status_reg[ulsl_pkg::LS_THRE] && tx_shift_empty)
    else $error("temt wrong");
  a_temt_shift: assert property (@(posedge clk) disable iff (!rst_ni)
    !tx_shift_empty |-> !line_status_reg[ulsl_pkg::LS_TEMT])
    else $error("temt set while shifting");
  a_thre_clears: assert property (@(posedge clk) disable iff (!rst_ni)
    tx_push |=> !line_status_reg[ulsl_pkg::LS_THRE])
    else $error("holding empty after write");

  // receive characters and their flags
  a_break_char: assert property (@(posedge clk) disable iff (!rst_ni)
    push && rx_frame_low |=> rx_flag_mem[$past(rx_wp_reg)][ulsl_pkg::LS_BI - ulsl_pkg::LS_PE])
    else $error("break flag lost");
  a_break_data: assert property (@(posedge clk) disable iff (!rst_ni)
    push && rx_frame_low |=> rx_data_mem[$past(rx_wp_reg)] == ulsl_pkg::BREAK_CHAR)
    else $error("break char not zero");
  a_head_flags: assert property (@(posedge clk) disable iff (!rst_ni)
    s_first_char |=> line_status_reg[ulsl_pkg::LS_BI:ulsl_pkg::LS_PE] == $past(in_flags))
    else $error("head flags wrong");
  a_dr_empty: assert property (@(posedge clk) disable iff (!rst_ni)
    s_first_char |=> line_status_reg[ulsl_pkg::LS_DR])
    else $error("data ready wrong");

  // overrun
  a_ovr_sets: assert property (@(posedge clk) disable iff (!rst_ni)
    rx_char_valid && rx_full |=> line_status_reg[ulsl_pkg::LS_OE])
    else $error("overrun not set");
  a_ovr_clear: assert property (@(posedge clk) disable iff (!rst_ni)
    rd_ls && !ovr_set |=> !line_status_reg[ulsl_pkg::LS_OE])
    else $error("overrun not cleared");
  a_rx_drop_full: assert property (@(posedge clk) disable iff (!rst_ni)
    rx_char_valid && rx_full && !pop && !rx_rst_reg && !mode_chg |=> rx_cnt_reg == $past(rx_cnt_reg))
    else $error("full fifo took a char");
  a_ovr_irq: assert property (@(posedge clk) disable iff (!rst_ni)
    ovr_set |=> ist_reg[ulsl_pkg::IRQ_OVR])
    else $error("overrun event lost");

  // reset and pointers
  a_reset_zero: assert property (@(posedge clk)
    $rose(rst_ni) |-> !line_status_reg[ulsl_pkg::LS_FERR] && line_status_reg[ulsl_pkg::LS_BI:ulsl_pkg::LS_DR] == 5'h00)
    else $error("status not zero after reset");
  a_ls_read_hold: assert property (@(posedge clk) disable iff (!rst_ni)
    rd_ls && !rx_rst_reg |=> rx_rp_reg == $past(rx_rp_reg))
    else $error("pointer moved");
  a_rhr_advance: assert property (@(posedge clk) disable iff (!rst_ni)
    pop && fifo_en_reg && !rx_rst_reg |=> rx_rp_reg == $past(rx_rp_reg) + ulsl_pkg::PTR_ONE)
    else $error("pointer not advanced");
  a_pop_one: assert property (@(posedge clk) disable iff (!rst_ni)
    s_clean_pop |=> rx_cnt_reg == $past(rx_cnt_reg) - ulsl_pkg::CNT_ONE)
    else $error("fill count not reduced");
  a_fifo_off_depth: assert property (@(posedge clk) disable iff (!rst_ni)
    !fifo_en_reg |-> rx_cnt_reg <= ulsl_pkg::CNT_ONE && tx_cnt_reg <= ulsl_pkg::CNT_ONE)
    else $error("depth above one while disabled");
  a_rxrst_clears: assert property (@(posedge clk) disable iff (!rst_ni)
    wr_fc && pwdata[ulsl_pkg::FC_RXRST] |=> ##1 rx_empty && !rx_rst_reg)
    else $error("rx reset failed");
  a_rxrst_self: assert property (@(posedge clk) disable iff (!rst_ni)
    rx_rst_reg && !wr_fc |=> !rx_rst_reg)
    else $error("rx reset stuck");
  a_tx_full_hold: assert property (@(posedge clk) disable iff (!rst_ni)
    wr_thr && !tx_push && !tx_pop && !mode_chg |=> tx_cnt_reg == $past(tx_cnt_reg))
    else $error("full tx fifo took a char");
endmodule : ulsl_line_status

// ==== tb/ulsl_far_model.sv ====
// Purpose: far side model, feeds received chars and drains tx chars
// Assumes: one received char per send request
// Notes: data lines invert on every clock between pulses
`timescale 1ns/1ps
module ulsl_far_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [10:0] word,
  input wire logic drain,
  input wire logic tx_char_valid,
  output logic rx_char_valid,
  output logic [7:0] rx_char_data,
  output logic rx_parity_bad,
  output logic rx_stop_bad,
  output logic rx_frame_low,
  output logic tx_shift_empty,
  output logic tx_take
);
  logic [2:0] busy_reg;
  initial begin
    {rx_char_valid, rx_char_data, rx_parity_bad, rx_stop_bad, rx_frame_low} = 12'h000;
    {tx_take, busy_reg} = 4'h0;
  end
  // word is {break, stop bad, parity bad, data}
  always @(posedge clk) begin
    rx_char_valid <= send;
    rx_char_data <= send ? word[7:0] : ~rx_char_data;
    {rx_frame_low, rx_stop_bad, rx_parity_bad} <= send ? word[10:8] : 3'h0;
    tx_take <= drain && tx_char_valid && !tx_take && busy_reg == 3'h0;
    busy_reg <= tx_take ? 3'h7 : (busy_reg != 3'h0 ? busy_reg - 3'h1 : 3'h0);
  end
  assign tx_shift_empty = (busy_reg == 3'h0) && !tx_take;
endmodule : ulsl_far_model

// ==== tb/test_uart_line_status_logic.sv ====
// Purpose: self-checking bench for the line status logic
// Assumes: zero wait apb slave, far model on the serial side
// Notes: expected status bytes are written out as hex constants
`timescale 1ns/1ps
module test_uart_line_status_logic;
  logic clk, rst_n, psel, penable, pwrite, send, drain, pready, pslverr, irq, err;
  logic rx_char_valid, rx_parity_bad, rx_stop_bad, rx_frame_low;
  logic tx_shift_empty, tx_take, tx_char_valid;
  logic [31:0] paddr, pwdata, prdata, rdat;
  logic [7:0] rx_char_data, tx_char_data;
  logic [10:0] word;
  int fail_count = 0;
  int num_checks = 0;
  localparam logic [7:0] A_LS = ulsl_pkg::ADDR_LINE_STATUS;
  localparam logic [7:0] A_RX = ulsl_pkg::ADDR_RX_HOLDING;
  localparam logic [7:0] A_FC = ulsl_pkg::ADDR_FIFO_CTRL;
  ulsl_line_status ulsl_line_status_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .rx_char_valid, .rx_char_data, .rx_parity_bad,
    .rx_stop_bad, .rx_frame_low, .tx_shift_empty, .tx_take, .tx_char_valid, .tx_char_data,
    .irq);
  ulsl_far_model ulsl_far_model_i (.clk, .send, .word, .drain, .tx_char_valid,
    .rx_char_valid, .rx_char_data, .rx_parity_bad, .rx_stop_bad, .rx_frame_low,
    .tx_shift_empty, .tx_take);
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {24'h000000, a};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) begin
      fail_count++;
      $display("MISMATCH pready expected 1 seen %h", pready);
      print_verdict();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rdat);
  endtask : rd
  task automatic snd(input logic [10:0] w);
    @(posedge clk);
    send <= 1'h1;
    word <= w;
    @(posedge clk);
    send <= 1'h0;
  endtask : snd
  // ==========================================================
  // scenarios
  task automatic t_disabled;
    rd("status reset", A_LS, 32'h60);
    snd(11'h011);
    snd(11'h022);
    rd("depth one overrun", A_LS, 32'h63);
    rd("overrun cleared", A_LS, 32'h61);
    rd("rhr first", A_RX, 32'h11);
  endtask : t_disabled
  task automatic t_flags;
    logic [10:0] w [4] = '{11'h041, 11'h142, 11'h243, 11'h4FF};
    logic [31:0] s [4] = '{32'hE1, 32'hE5, 32'hE9, 32'hF1};
    logic [31:0] d [4] = '{32'h41, 32'h42, 32'h43, 32'h00};
    apb(1'h1, A_FC, 32'h1);
    foreach (w[i]) snd(w[i]);
    rd("status first", A_LS, s[0]);
    foreach (d[i]) begin
      rd("status head", A_LS, s[i]);
      rd("rhr pop", A_RX, d[i]);
    end
    rd("status drained", A_LS, 32'h60);
  endtask : t_flags
  task automatic t_overrun;
    repeat (64) snd(11'h055);
    rd("status full", A_LS, 32'h61);
    snd(11'h056);
    rd("status overrun", A_LS, 32'h63);
    rd("overrun read clr", A_LS, 32'h61);
    apb(1'h1, A_FC, 32'h3);
    rd("fifo reset", A_LS, 32'h60);
    snd(11'h057);
    rd("rhr after reset", A_RX, 32'h57);
  endtask : t_overrun
  task automatic t_tx;
    logic saw = 1'h0;
    apb(1'h1, ulsl_pkg::ADDR_TX_HOLDING, 32'hA5);
    apb(1'h1, ulsl_pkg::ADDR_TX_HOLDING, 32'h5A);
    rd("tx pending", A_LS, 32'h00);
    chk("tx head", 32'hA5, {24'h000000, tx_char_data});
    chk("tx valid", 32'h1, {31'h0, tx_char_valid});
    drain <= 1'h1;
    for (int i = 0; i < 40 && rdat !== 32'h60; i++) begin
      apb(1'h0, A_LS, 32'h0);
      saw = saw | (rdat === 32'h20);
    end
    chk("shift busy seen", 32'h1, {31'h0, saw});
    chk("tx empty", 32'h60, rdat);
  endtask : t_tx
  task automatic t_irq;
    apb(1'h1, ulsl_pkg::ADDR_IRQ_STATUS, 32'hF);
    apb(1'h1, ulsl_pkg::ADDR_IRQ_MASK, 32'h1);
    snd(11'h077);
    rd("irq status", ulsl_pkg::ADDR_IRQ_STATUS, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'h1, ulsl_pkg::ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rd("rhr", A_RX, 32'h77);
    chk("mapped no err", 32'h0, {31'h0, err});
    apb(1'h0, 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
  endtask : t_irq
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // ==========================================================
  // clock, reset, sequence, watchdog
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rst_n, psel, penable, pwrite, send, drain, paddr, pwdata, word} = 81'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge clk);
    t_disabled();
    t_flags();
    t_overrun();
    t_tx();
    t_irq();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule : test_uart_line_status_logic
